/* File: logic/sadc_top.sv */
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
// Contract
// - Three-bit channel field, bits six to four, routes one analog input.
// - Software sets bit zero; device then starts a conversion on that channel.
// - Approximation register starts each conversion at mid-scale 800H.
// - One channel per conversion; ten bit trials update the register automatically.
// - Completion sets end-of-conversion flag, control bit three.
// - Completion copies the result to the result bytes, then goes idle.
// - Each new result overwrites the old; software reads in time.
// - Ten set-up clocks plus four clocks per bit: fifty conversion clocks.
// - Control bits two and one pick the conversion clock divider, one is eight.
// - Reset clears the start bit; nothing runs after reset.
// - Channel field may be rewritten between conversions.
// - Control register is read and write at its own address.
module sadc_top #(
	parameter int ADDR_W = 12 // APB address width
) (
	input  wire logic              pclk,       // System clock, 40 MHz
	input  wire logic              presetn,    // Async reset, active low
	input  wire logic              psel,       // APB select
	input  wire logic              penable,    // APB access phase
	input  wire logic              pwrite,     // APB write
	input  wire logic [ADDR_W-1:0] paddr,      // APB byte address
	input  wire logic [31:0]       pwdata,     // APB write data
	output logic      [31:0]       prdata,     // APB read data
	output logic                   pready,     // APB ready
	output logic                   pslverr,    // APB error, unmapped
	input  wire logic              comp_in,    // Comparator, high: input above trial
	output logic      [2:0]        analog_sel, // Analog input mux select
	output logic      [9:0]        dac_code,   // Trial code to resistor string
	output logic                   conv_busy,  // Conversion running
	output logic                   irq         // Interrupt, level
);

	sadc_pkg::sadc_ctrl_s  ctrl;
	sadc_pkg::sadc_ctrl_s  next_ctrl;
	sadc_pkg::sadc_state_e state;
	sadc_pkg::sadc_state_e next_state;

	logic [9:0]  result;
	logic [11:0] sar;
	logic [11:0] trial_mask;
	logic [11:0] next_sar;
	logic [3:0]  setup_cnt;
	logic [1:0]  step;
	logic [1:0]  conv_div;
	logic        int_stat;
	logic        int_mask;
	logic        comp_q;
	logic        tick;
	logic [11:0] busy_cyc;

	if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
		$error("sadc_top: ADDR_W must lie in 10..32");
	end

	// APB phase decode
	wire setup_ph = psel & ~penable;
	wire access   = psel & penable & pready;
	wire wr_en    = access & pwrite;

	// Address decode, word aligned, page above bit nine must be zero
	wire [7:0] idx     = paddr[9:2];
	wire       in_page = ((paddr >> 10) == '0) && (paddr[1:0] == 2'b00);
	wire       hit_ctrl = in_page && idx == sadc_pkg::IDX_CTRL;
	wire       hit_resh = in_page && idx == sadc_pkg::IDX_RES_HIGH;
	wire       hit_resl = in_page && idx == sadc_pkg::IDX_RES_LOW;
	wire       hit_stat = in_page && idx == sadc_pkg::IDX_INT_STAT;
	wire       hit_mask = in_page && idx == sadc_pkg::IDX_INT_MASK;
	wire       hit_any  = hit_ctrl | hit_resh | hit_resl | hit_stat | hit_mask;

	// Write strobes; result bytes have none at all
	wire wr_ctrl = wr_en & hit_ctrl;
	wire wr_stat = wr_en & hit_stat;
	wire wr_mask = wr_en & hit_mask;

	// Sequencer decode
	wire st_idle  = (state == sadc_pkg::ST_IDLE);
	wire st_setup = (state == sadc_pkg::ST_SETUP);
	wire st_trial = (state == sadc_pkg::ST_TRIAL);
	wire begin_cv = st_idle & ctrl.start;
	wire abort_cv = ~st_idle & ~ctrl.start;
	wire setup_end = st_setup & tick & (setup_cnt == sadc_pkg::SETUP_LAST);
	wire bit_end  = st_trial & tick & (step == sadc_pkg::STEP_LAST);
	wire last_bit = (trial_mask == sadc_pkg::SAR_LAST);
	wire done     = bit_end & last_bit & ctrl.start;

	// Divider ratio of the running conversion
	wire [4:0] div_ratio =
		(conv_div == 2'h0) ? sadc_pkg::DIV_RATIO_0 :
		(conv_div == 2'h1) ? sadc_pkg::DIV_RATIO_1 :
		(conv_div == 2'h2) ? sadc_pkg::DIV_RATIO_2 :
		sadc_pkg::DIV_RATIO_3;

	// Bit decision: keep the trial bit if input is above, then try the next
	wire [11:0] kept     = comp_q ? sar : (sar & ~trial_mask);
	wire [11:0] next_try = last_bit ? 12'h000 : (trial_mask >> 1);
	assign next_sar = kept | next_try;

	// Read mux; low byte pads its unused bits with zero
	wire [7:0] rd_byte =
		hit_ctrl ? {1'b0, ctrl[6:0]} :
		hit_resh ? result[9:2] :
		hit_resl ? {result[1:0], 6'h00} :
		hit_stat ? {7'h00, int_stat} :
		hit_mask ? {7'h00, int_mask} :
		8'h00;

	// Trial code follows the register; a flop feeds it directly
	assign dac_code = sar[11:2];

	// Comparator crosses in from the analog side
	sadc_sync u_comp_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (comp_in),
		.q       (comp_q)
	);

	// Divider phase restarts with each conversion
	sadc_clkdiv #(
		.CNT_W (5)
	) u_clkdiv (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (begin_cv),
		.ratio   (div_ratio),
		.tick    (tick)
	);

	// Control register next value; a software start beats the hardware clear
	always_comb begin
		next_ctrl = ctrl;
		if (done) begin
			next_ctrl.start = 1'b0;
			next_ctrl.eoc   = 1'b1;
		end
		if (wr_ctrl) begin
			next_ctrl.chan  = pwdata[6:4];
			next_ctrl.div   = pwdata[2:1];
			next_ctrl.start = pwdata[0];
		end
		if (begin_cv) begin
			next_ctrl.eoc = 1'b0;
		end
		next_ctrl.rsv = 1'b0;
	end

	// Sequencer next state; writing a zero start aborts
	always_comb begin
		next_state = state;
		unique case (state)
			sadc_pkg::ST_IDLE: begin
				if (ctrl.start) begin
					next_state = sadc_pkg::ST_SETUP;
				end
			end
			sadc_pkg::ST_SETUP: begin
				if (abort_cv) begin
					next_state = sadc_pkg::ST_IDLE;
				end else if (setup_end) begin
					next_state = sadc_pkg::ST_TRIAL;
				end
			end
			sadc_pkg::ST_TRIAL: begin
				if (abort_cv || done) begin
					next_state = sadc_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = sadc_pkg::ST_IDLE;
			end
		endcase
	end

	// Control and state registers; reset leaves nothing running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl  <= sadc_pkg::CTRL_RESET;
			state <= sadc_pkg::ST_IDLE;
		end else begin
			ctrl  <= next_ctrl;
			state <= next_state;
		end
	end

	// Conversion start latches channel and divider for the whole run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_sel <= 3'h0;
			conv_div   <= 2'h0;
		end else if (begin_cv) begin
			analog_sel <= ctrl.chan;
			conv_div   <= ctrl.div;
		end
	end

	// Set-up count and bit step count, both in conversion clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_cnt <= 4'h0;
			step      <= 2'h0;
		end else if (begin_cv) begin
			setup_cnt <= 4'h0;
			step      <= 2'h0;
		end else if (tick && st_setup) begin
			setup_cnt <= setup_cnt + 4'h1;
		end else if (tick && st_trial) begin
			step <= step + 2'h1;
		end
	end

	// Approximation register and trial bit, one decision per four ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sar        <= 12'h000;
			trial_mask <= 12'h000;
		end else if (begin_cv) begin
			sar        <= sadc_pkg::SAR_INIT;
			trial_mask <= sadc_pkg::SAR_INIT;
		end else if (bit_end) begin
			sar        <= next_sar;
			trial_mask <= trial_mask >> 1;
		end
	end

	// Result is overwritten by every finished conversion, read or not
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result <= sadc_pkg::RESULT_RESET;
		end else if (done) begin
			result <= next_sar[11:2];
		end
	end

	// Done flag is sticky; a new event wins over a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat <= 1'b0;
			int_mask <= 1'b0;
			irq      <= 1'b0;
		end else begin
			int_stat <= done | (int_stat & ~(wr_stat & pwdata[0]));
			if (wr_mask) begin
				int_mask <= pwdata[0];
			end
			irq <= int_stat & int_mask;
		end
	end

	// Busy mirrors the next state so it rises with the set-up phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_busy <= 1'b0;
		end else begin
			conv_busy <= (next_state != sadc_pkg::ST_IDLE);
		end
	end

	// Zero wait states: ready follows setup by one edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~hit_any;
			if (setup_ph) begin
				prdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	// Helper: pclk cycles spent in the current conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_cyc <= 12'h000;
		end else if (begin_cv) begin
			busy_cyc <= 12'h000;
		end else if (!st_idle) begin
			busy_cyc <= busy_cyc + 12'h001;
		end
	end

	chk_sar_midscale: assert property (@(posedge pclk) disable iff (!presetn)
		begin_cv |=> sar == sadc_pkg::SAR_INIT && st_setup)
		else $error("approximation register not at mid-scale after start");

	chk_start_taken: assert property (@(posedge pclk) disable iff (!presetn)
		st_idle && ctrl.start |=> conv_busy && st_setup)
		else $error("set start bit did not begin a conversion");

	chk_eoc_on_done: assert property (@(posedge pclk) disable iff (!presetn)
		done |=> ctrl.eoc && st_idle && int_stat
			&& ctrl.start == $past(wr_ctrl && pwdata[0]))
		else $error("completion did not raise end-of-conversion");

	chk_eoc_cleared: assert property (@(posedge pclk) disable iff (!presetn)
		begin_cv |=> !ctrl.eoc)
		else $error("end-of-conversion survived a new start");

	chk_result_load: assert property (@(posedge pclk) disable iff (!presetn)
		done |=> result == $past(next_sar[11:2]) && !conv_busy)
		else $error("result not loaded on completion");

	chk_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
		done |-> busy_cyc == 12'(div_ratio) * sadc_pkg::CONV_TICKS - 12'h001)
		else $error("conversion length is not fifty conversion clocks");

	chk_result_ro: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && (hit_resh || hit_resl) && !done |=> $stable(result))
		else $error("software write changed the result");

	chk_chan_latch: assert property (@(posedge pclk) disable iff (!presetn)
		begin_cv ##1 (!st_idle)[*2] |-> analog_sel == $past(ctrl.chan, 2))
		else $error("channel select moved during a conversion");

	chk_chan_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> ctrl.chan == $past(pwdata[6:4]))
		else $error("channel field write lost");

	chk_trial_shift: assert property (@(posedge pclk) disable iff (!presetn)
		bit_end && !last_bit |=> trial_mask == $past(trial_mask) >> 1
			&& (sar & trial_mask) != 12'h000)
		else $error("next trial bit not set after a decision");

	// Only a finished conversion may touch the result
	chk_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!done |=> $stable(result))
		else $error("result changed without a finished conversion");

	// An aborted run ends at once and never claims completion
	chk_abort_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		abort_cv |=> st_idle && !conv_busy && !ctrl.eoc)
		else $error("abort did not stop the sequencer cleanly");

	// Every setup cycle is answered on the next edge
	chk_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
		setup_ph |=> pready && pslverr == !$past(hit_any))
		else $error("register access not answered in one cycle");

endmodule

/* File: logic/sadc_pkg.sv */
package sadc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL     = 8'h5c;
	localparam logic [7:0] IDX_RES_HIGH = 8'h5d;
	localparam logic [7:0] IDX_RES_LOW  = 8'h5e;
	localparam logic [7:0] IDX_INT_STAT = 8'h58;
	localparam logic [7:0] IDX_INT_MASK = 8'h59;

	// Reset values
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [9:0] RESULT_RESET = 10'h000;

	// Result low byte: bits one and zero sit in the top two bits
	localparam int RES_LOW_SHIFT = 6;

	// Approximation register: mid-scale start, last trial bit
	localparam logic [11:0] SAR_INIT = 12'h800;
	localparam logic [11:0] SAR_LAST = 12'h004;

	// Conversion timing in conversion clocks
	localparam logic [3:0]  SETUP_LAST = 4'h9;
	localparam logic [1:0]  STEP_LAST  = 2'h3;
	localparam logic [11:0] CONV_TICKS = 12'h032;

	// Conversion clock ratios selected by control bits two and one
	localparam logic [4:0] DIV_RATIO_0 = 5'h10;
	localparam logic [4:0] DIV_RATIO_1 = 5'h08;
	localparam logic [4:0] DIV_RATIO_2 = 5'h04;
	localparam logic [4:0] DIV_RATIO_3 = 5'h02;

	// Least whole conversion time, software's concern
	localparam int PCLK_HZ        = 40_000_000;
	localparam int T_CONV_MIN_NS  = 25_000;
	localparam int CONV_MIN_CYC   = (T_CONV_MIN_NS * (PCLK_HZ / 1_000_000) + 999) / 1000;

	// Control register layout, bit seven reads zero
	typedef struct packed {
		logic       rsv;
		logic [2:0] chan;
		logic       eoc;
		logic [1:0] div;
		logic       start;
	} sadc_ctrl_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SETUP = 3'b010,
		ST_TRIAL = 3'b100
	} sadc_state_e;

endpackage

/* File: logic/sadc_sync.sv */
`timescale 1ns/10ps
module sadc_sync (
	input  wire logic pclk,    // System clock
	input  wire logic presetn, // Async reset, active low
	input  wire logic d,       // Asynchronous level
	output logic      q        // Filtered synchronous level
);

	logic s1;
	logic s2;
	logic s3;

	// Three stages; only the agreeing pair two/three may move the output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			q  <= 1'b0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				q <= s3;
			end
		end
	end

endmodule

/* File: logic/sadc_clkdiv.sv */
`timescale 1ns/10ps
module sadc_clkdiv #(
	parameter int CNT_W = 5 // Counter width
) (
	input  wire logic             pclk,    // System clock
	input  wire logic             presetn, // Async reset, active low
	input  wire logic             clr,     // Restart phase
	input  wire logic [CNT_W-1:0] ratio,   // Division ratio
	output logic                  tick     // One conversion clock
);

	logic [CNT_W-1:0] cnt;

	if (CNT_W < 2) begin : g_bad_width
		$error("sadc_clkdiv: CNT_W too small");
	end

	// Tick on the last count of each period
	assign tick = (cnt == ratio - CNT_W'(1));

	// Restart keeps conversion length exact from its first cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (clr || tick) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + CNT_W'(1);
		end
	end

	chk_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		tick && !clr && ratio > CNT_W'(1) |=> !tick)
		else $error("conversion clock ticks on adjacent cycles");

endmodule

/* File: verif/test_sar_adc_sequencer.sv */
`timescale 1ns/10ps
module test_sar_adc_sequencer;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        comp_in;
	logic [2:0]  analog_sel;
	logic [9:0]  dac_code;
	logic        conv_busy;
	logic        irq;
	logic [9:0]  level;     // Analog level seen by the comparator
	logic [31:0] rdata;     // Last read data
	logic        rerr;      // Last error response
	int          err_count;
	int          compares;

	sadc_top #(.ADDR_W(12)) dut (
		.pclk       (pclk),
		.presetn    (presetn),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.comp_in    (comp_in),
		.analog_sel (analog_sel),
		.dac_code   (dac_code),
		.conv_busy  (conv_busy),
		.irq        (irq)
	);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Comparator: keep the trial bit while the level is at or above it
	always @(posedge pclk) begin
		comp_in <= (level >= dac_code);
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		if (err_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic timeout();
		err_count++;
		$display("FAIL t=%0t wait limit got=%h exp=%h", $time, 32'h0, 32'h1);
		finish_test();
	endtask

	// One APB transfer; a spare edge after it keeps strobes from toggling twice
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
			if (n > 20) timeout();
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Bounded wait for the sequencer to go idle
	task automatic wait_idle();
		int n;
		n = 0;
		while (conv_busy !== 1'b0) begin
			@(posedge pclk);
			n++;
			if (n > 1000) timeout();
		end
	endtask

	// Full conversion: timing, trial start, channel, flags and result bytes
	task automatic convert(input logic [2:0] ch, input logic [1:0] dv, input logic [9:0] lv);
		int n;
		int r;
		n = 0;
		r = 16 >> dv;
		level <= lv; // pin already serves as analog input
		apb(1'b1, sadc_pkg::IDX_CTRL, {1'b0, ch, 1'b0, dv, 1'b1});
		while (conv_busy !== 1'b1) begin
			@(posedge pclk);
			n++;
			if (n > 8) timeout();
		end
		check({22'h0, dac_code}, 32'h200);
		check({29'h0, analog_sel}, {29'h0, ch});
		n = 1;
		while (conv_busy === 1'b1) begin
			@(posedge pclk);
			if (conv_busy === 1'b1) n++;
			if (n > 900) timeout();
		end
		check(32'(n), 32'(50 * r));
		apb(1'b0, sadc_pkg::IDX_CTRL, 8'h00);
		check(rdata, {24'h0, 1'b0, ch, 1'b1, dv, 1'b0});
		apb(1'b0, sadc_pkg::IDX_RES_HIGH, 8'h00);
		check(rdata, {24'h0, lv[9:2]});
		apb(1'b0, sadc_pkg::IDX_RES_LOW, 8'h00);
		check(rdata, {24'h0, lv[1:0], 6'h00});
	endtask

	task automatic scen_reset();
		apb(1'b0, sadc_pkg::IDX_CTRL, 8'h00);
		check(rdata, 32'h0);
		check({31'h0, conv_busy}, 32'h0);
		apb(1'b0, 8'h00, 8'h00);
		check({31'h0, rerr}, 32'h1);
		check(rdata, 32'h0);
	endtask

	// Bit seven and the done flag cannot be written; start left off
	task automatic scen_ctrl_rw();
		apb(1'b1, sadc_pkg::IDX_CTRL, 8'hf6);
		apb(1'b0, sadc_pkg::IDX_CTRL, 8'h00);
		check(rdata, 32'h76);
		apb(1'b1, sadc_pkg::IDX_CTRL, 8'h0e);
		apb(1'b0, sadc_pkg::IDX_CTRL, 8'h00);
		check(rdata, 32'h06);
		check({31'h0, conv_busy}, 32'h0);
	endtask

	// Every divider code, a new channel and level each time
	task automatic scen_convert_all();
		logic [9:0] lv [4];
		lv = '{10'h3ff, 10'h000, 10'h155, 10'h2a6};
		for (int d = 0; d < 4; d++) begin
			convert(3'(2 * d + 1), 2'(d), lv[d]);
		end
	endtask

	// A new start hides the previous done flag while running
	task automatic scen_restart();
		level <= 10'h0ab;
		apb(1'b1, sadc_pkg::IDX_CTRL, 8'h51);
		apb(1'b0, sadc_pkg::IDX_CTRL, 8'h00);
		check(rdata, 32'h51);
		check({31'h0, conv_busy}, 32'h1);
		wait_idle();
		apb(1'b0, sadc_pkg::IDX_RES_HIGH, 8'h00);
		check(rdata, 32'h2a);
	endtask

	// Writing a zero start mid-run stops it: no flag, old result kept
	task automatic scen_abort();
		apb(1'b1, sadc_pkg::IDX_CTRL, 8'h47);
		repeat (20) @(posedge pclk);
		apb(1'b1, sadc_pkg::IDX_CTRL, 8'h40);
		repeat (120) @(posedge pclk);
		check({31'h0, conv_busy}, 32'h0);
		apb(1'b0, sadc_pkg::IDX_CTRL, 8'h00);
		check(rdata, 32'h40);
		apb(1'b0, sadc_pkg::IDX_RES_HIGH, 8'h00);
		check(rdata, 32'h2a);
	endtask

	// Reset in mid-conversion leaves nothing running
	task automatic scen_reset_mid();
		apb(1'b1, sadc_pkg::IDX_CTRL, 8'h27);
		repeat (10) @(posedge pclk);
		check({31'h0, conv_busy}, 32'h1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check({19'h0, analog_sel, dac_code}, 32'h0);
		repeat (120) @(posedge pclk);
		check({31'h0, conv_busy}, 32'h0);
		apb(1'b0, sadc_pkg::IDX_CTRL, 8'h00);
		check(rdata, 32'h0);
	endtask

	task automatic scen_result_ro();
		apb(1'b1, sadc_pkg::IDX_RES_HIGH, 8'hff);
		check({31'h0, rerr}, 32'h0);
		apb(1'b1, sadc_pkg::IDX_RES_LOW, 8'h3f);
		apb(1'b0, sadc_pkg::IDX_RES_HIGH, 8'h00);
		check(rdata, 32'h2a);
		apb(1'b0, sadc_pkg::IDX_RES_LOW, 8'h00);
		check(rdata, 32'hc0);
	endtask

	// Done event: masked, unmasked, then cleared by writing one
	task automatic scen_irq();
		apb(1'b0, sadc_pkg::IDX_INT_STAT, 8'h00);
		check(rdata, 32'h1);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, sadc_pkg::IDX_INT_MASK, 8'h01);
		@(posedge pclk);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, sadc_pkg::IDX_INT_STAT, 8'h01);
		@(posedge pclk);
		check({31'h0, irq}, 32'h0);
		apb(1'b0, sadc_pkg::IDX_INT_STAT, 8'h00);
		check(rdata, 32'h0);
	endtask

	initial begin
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 12'h000;
		pwdata    = 32'h0;
		level     = 10'h000;
		err_count = 0;
		compares  = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		scen_reset();
		scen_ctrl_rw();
		scen_convert_all();
		scen_restart();
		scen_result_ro();
		scen_abort();
		scen_irq();
		scen_reset_mid();
		finish_test();
	end

	// Whole-run limit as a last guard
	initial begin
		#2_500_000;
		timeout();
	end
endmodule
